/* hdl/hbi_regs.svh */
// Purpose: Constants of the host bus interface: register indices,
//          reset values and timing counts.
// Assumes: 100 MHz system clock on both ends.
// Notes:   Included by both ends; definitions only.
`ifndef HBI_REGS_SVH
`define HBI_REGS_SVH

// --------------------------------------------------------------
// Register indices
// --------------------------------------------------------------
`define HBI_IDX_CFG0      2'h0
`define HBI_IDX_CFG1      2'h1
`define HBI_IDX_OVF       2'h2
`define HBI_IDX_MASK      2'h3

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define HBI_RST_CFG       8'h00
`define HBI_RST_OVF       8'h00
`define HBI_RST_MASK      8'hFF
`define HBI_BUS_IDLE      8'hFF

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define HBI_CLK_NS        10
`define HBI_CLEAR_MIN_CLK 4
`define HBI_PHASE_NS      120
`define HBI_PHASE_CYC     ((`HBI_PHASE_NS + `HBI_CLK_NS - 1) / `HBI_CLK_NS)

`endif

/* hdl/hbi_pkg.sv */
// Purpose: Types shared by both ends of the host bus interface.
// Assumes: Eight-bit shared bus, four internal registers.
// Notes:   State of each end is one packed struct.
package hbi_pkg;

    localparam int HBI_DW   = 8;
    localparam int HBI_AW   = 2;
    localparam int HBI_NREG = 4;

    typedef logic [HBI_DW-1:0] hbi_byte_t;
    typedef logic [HBI_AW-1:0] hbi_addr_t;

    typedef enum logic [2:0] {
        HS_CLEAR,
        HS_IDLE,
        HS_ADDR,
        HS_GAP,
        HS_STRB,
        HS_END
    } hbi_host_fsm_t;

    typedef struct packed {
        hbi_byte_t [HBI_NREG-1:0] regs;
        hbi_addr_t                addr;
        logic                     wr_act;
        hbi_byte_t                wdata;
        hbi_byte_t                bus_out;
        logic                     bus_oe;
        logic                     irq_oe;
        logic                     irq_out;
        logic                     wr_pulse;
        hbi_addr_t                wr_idx;
    } hbi_dev_st_t;

    typedef struct packed {
        hbi_host_fsm_t fsm;
        logic [7:0]    cnt;
        logic          write;
        hbi_addr_t     addr;
        hbi_byte_t     wdata;
        logic          cs_n;
        logic          strobe_a;
        logic          strobe_b;
        logic          ale;
        hbi_addr_t     sel;
        hbi_byte_t     bus_out;
        logic          bus_oe;
        logic          clear;
        hbi_byte_t     rdata;
        logic          done;
        logic          busy;
        logic          irq;
    } hbi_host_st_t;

endpackage

/* hdl/hbi_if.sv */
// Purpose: Pins between host and device, with wire resolution.
// Assumes: External pull-ups on shared bus and interrupt line.
// Notes:   strobe_a is read strobe or data_strobe, strobe_b is
//          write strobe or direction, per bus style.
interface hbi_if;
    import hbi_pkg::*;

    logic      cs_n;
    logic      strobe_a;
    logic      strobe_b;
    logic      ale;
    hbi_addr_t reg_select;
    logic      device_clear_in;
    hbi_byte_t bus_host_out;
    logic      bus_host_oe;
    hbi_byte_t bus_dev_out;
    logic      bus_dev_oe;
    logic      irq_dev_out;
    logic      irq_dev_oe;
    hbi_byte_t shared_bus;
    logic      irq_n;

    // Pull-ups win when nobody drives
    assign shared_bus = bus_dev_oe ? bus_dev_out
                      : (bus_host_oe ? bus_host_out : 8'hFF);
    assign irq_n      = irq_dev_oe ? irq_dev_out : 1'b1;

    modport dev (
        input  cs_n, strobe_a, strobe_b, ale, reg_select,
        input  device_clear_in, shared_bus,
        output bus_dev_out, bus_dev_oe, irq_dev_out, irq_dev_oe
    );

    modport host (
        output cs_n, strobe_a, strobe_b, ale, reg_select,
        output device_clear_in, bus_host_out, bus_host_oe,
        input  shared_bus, irq_n
    );

endinterface

/* hdl/hbi_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs asynchronous to clock_i.
// Notes:   A bit changes once stages two and three agree.
module hbi_sync #(
    parameter int             W   = 8,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         clock_i,
    input  wire logic         sys_rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } hbi_sync_st_t;

    hbi_sync_st_t st_ff;
    hbi_sync_st_t nxt_st;

    // First stage feeds only the second
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = async_i;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < W; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.q[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_ff <= {RST, RST, RST, RST};
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign sync_o = st_ff.q;

endmodule

/* hdl/hbi_dev.sv */
// Purpose: Device end of the host bus interface: strobe decode,
//          register file, overflow flags and interrupt.
// Assumes: All pins asynchronous; host phases last well over
//          the four-cycle synchroniser delay.
// Notes:   Reads show register state a few cycles after strobe.
module hbi_dev
    import hbi_pkg::*;
(
    input  wire logic      clock_i,
    input  wire logic      sys_rst_i,
    input  wire logic      ce_i,
    input  wire logic      ds_style_i,
    input  wire logic      mux_mode_i,
    input  wire hbi_byte_t ovf_event_i,
    output hbi_byte_t      cfg0_o,
    output hbi_byte_t      cfg1_o,
    output hbi_byte_t      conference_overflow_flags_o,
    output logic           irq_pending_o,
    output logic           wr_pulse_o,
    output hbi_addr_t      wr_idx_o,
    hbi_if.dev             bus
);
    `include "hbi_regs.svh"

    // --------------------------------------------------------------
    // Reset state
    // --------------------------------------------------------------
    localparam hbi_dev_st_t DEV_RST = '{
        regs:     {`HBI_RST_MASK, `HBI_RST_OVF,
                   `HBI_RST_CFG, `HBI_RST_CFG},
        addr:     '0,
        wr_act:   1'b0,
        wdata:    '0,
        bus_out:  '0,
        bus_oe:   1'b0,
        irq_oe:   1'b0,
        irq_out:  1'b0,
        wr_pulse: 1'b0,
        wr_idx:   '0
    };

    localparam int SW = 7 + HBI_AW + HBI_DW - 2 - HBI_AW + HBI_AW;
    localparam logic [SW-1:0] SYNC_RST =
        {1'b0, 1'b1, 1'b1, 1'b1, 1'b0, {HBI_AW{1'b0}}, `HBI_BUS_IDLE};

    // --------------------------------------------------------------
    // Strobe decode
    // --------------------------------------------------------------
    // Read is active while selected and the strobe is low
    function automatic logic read_on(input logic ds, input logic cs_n,
                                     input logic a, input logic b);
        read_on = ~cs_n & (ds ? (~a & b) : ~a);
    endfunction

    function automatic logic write_on(input logic ds, input logic cs_n,
                                      input logic a, input logic b);
        write_on = ~cs_n & (ds ? (~a & ~b) : ~b);
    endfunction

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    logic [SW-1:0] pins_s;
    logic          s_clear;
    logic          s_cs_n;
    logic          s_a;
    logic          s_b;
    logic          s_ale;
    hbi_addr_t     s_sel;
    hbi_byte_t     s_bus;

    hbi_sync #(
        .W   (SW),
        .RST (SYNC_RST)
    ) u_sync (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .async_i   ({bus.device_clear_in, bus.cs_n, bus.strobe_a,
                     bus.strobe_b, bus.ale, bus.reg_select,
                     bus.shared_bus}),
        .sync_o    (pins_s)
    );

    assign {s_clear, s_cs_n, s_a, s_b, s_ale, s_sel, s_bus} = pins_s;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    hbi_dev_st_t st_ff;
    hbi_dev_st_t nxt_st;
    hbi_addr_t   eff_idx;
    logic        rd_now;
    logic        wr_now;
    logic        commit;
    hbi_byte_t   ovf_clr;

    always_comb begin
        nxt_st = st_ff;

        // Address phase on the shared bus
        if (mux_mode_i && s_ale) begin
            nxt_st.addr = s_bus[HBI_AW-1:0];
        end

        // Latched address stays until the next address phase
        eff_idx = mux_mode_i ? st_ff.addr : s_sel;

        rd_now = read_on(ds_style_i, s_cs_n, s_a, s_b);
        wr_now = write_on(ds_style_i, s_cs_n, s_a, s_b);

        // Completion on the strobe's rising edge while still selected
        commit = st_ff.wr_act & ~s_cs_n
               & (ds_style_i ? s_a : s_b);

        nxt_st.wr_act = wr_now;
        // Data captured during the strobe, so late bus changes
        // at the rising edge cannot corrupt the write
        if (wr_now) begin
            nxt_st.wdata = s_bus;
        end

        nxt_st.wr_pulse = commit;
        if (commit) begin
            nxt_st.wr_idx = eff_idx;
        end

        ovf_clr = '0;
        if (commit && eff_idx == `HBI_IDX_OVF) begin
            ovf_clr = st_ff.wdata;
        end else if (commit) begin
            nxt_st.regs[eff_idx] = st_ff.wdata;
        end

        // Write one to clear; a new event wins over its clear
        nxt_st.regs[`HBI_IDX_OVF] = (st_ff.regs[`HBI_IDX_OVF] & ~ovf_clr)
                                  | ovf_event_i;

        // Drive only during a selected read
        nxt_st.bus_oe  = rd_now;
        nxt_st.bus_out = st_ff.regs[eff_idx];

        // Pull low only; the line is released otherwise
        nxt_st.irq_out = 1'b0;
        nxt_st.irq_oe  = |(nxt_st.regs[`HBI_IDX_OVF]
                          & ~nxt_st.regs[`HBI_IDX_MASK]);

        // Clear pin acts as a synchronous reset
        if (s_clear) begin
            nxt_st = DEV_RST;
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_ff <= DEV_RST;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign bus.bus_dev_out = st_ff.bus_out;
    assign bus.bus_dev_oe  = st_ff.bus_oe;
    assign bus.irq_dev_out = st_ff.irq_out;
    assign bus.irq_dev_oe  = st_ff.irq_oe;

    assign cfg0_o                      = st_ff.regs[`HBI_IDX_CFG0];
    assign cfg1_o                      = st_ff.regs[`HBI_IDX_CFG1];
    assign conference_overflow_flags_o = st_ff.regs[`HBI_IDX_OVF];
    assign irq_pending_o               = st_ff.irq_oe;
    assign wr_pulse_o                  = st_ff.wr_pulse;
    assign wr_idx_o                    = st_ff.wr_idx;

endmodule

/* hdl/hbi_host.sv */
// Purpose: Host end: turns register requests into pin phases.
// Assumes: One request at a time; req_i taken only when idle.
// Notes:   Each phase lasts a fixed count to cover device latency.
module hbi_host
    import hbi_pkg::*;
(
    input  wire logic      clock_i,
    input  wire logic      sys_rst_i,
    input  wire logic      ce_i,
    input  wire logic      ds_style_i,
    input  wire logic      mux_mode_i,
    input  wire logic      req_i,
    input  wire logic      req_write_i,
    input  wire hbi_addr_t req_addr_i,
    input  wire hbi_byte_t req_wdata_i,
    output logic           busy_o,
    output logic           done_o,
    output hbi_byte_t      rdata_o,
    output logic           irq_o,
    hbi_if.host            bus
);
    `include "hbi_regs.svh"

    localparam logic [7:0] PH_LAST = 8'(`HBI_PHASE_CYC - 1);
    localparam logic [7:0] CL_LAST = 8'(`HBI_CLEAR_MIN_CLK - 1);

    localparam hbi_host_st_t HOST_RST = '{
        fsm: HS_CLEAR, cnt: '0, write: 1'b0, addr: '0, wdata: '0,
        cs_n: 1'b1, strobe_a: 1'b1, strobe_b: 1'b1, ale: 1'b0,
        sel: '0, bus_out: '0, bus_oe: 1'b0, clear: 1'b1,
        rdata: '0, done: 1'b0, busy: 1'b1, irq: 1'b0
    };

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    logic      s_irq_n;
    hbi_byte_t s_bus;

    hbi_sync #(
        .W   (HBI_DW + 1),
        .RST ({1'b1, `HBI_BUS_IDLE})
    ) u_sync (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .async_i   ({bus.irq_n, bus.shared_bus}),
        .sync_o    ({s_irq_n, s_bus})
    );

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    hbi_host_st_t st_ff;
    hbi_host_st_t nxt_st;
    logic         last;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.irq  = ~s_irq_n;
        last        = (st_ff.cnt == PH_LAST);
        nxt_st.cnt  = st_ff.cnt + 8'h01;
        case (st_ff.fsm)
            HS_CLEAR: begin
                if (st_ff.cnt == CL_LAST) begin
                    nxt_st.fsm   = HS_IDLE;
                    nxt_st.busy  = 1'b0;
                    nxt_st.clear = 1'b0;
                end
            end
            HS_IDLE: begin
                nxt_st.cnt = '0;
                if (req_i) begin
                    nxt_st.busy  = 1'b1;
                    nxt_st.write = req_write_i;
                    nxt_st.addr  = req_addr_i;
                    nxt_st.wdata = req_wdata_i;
                    nxt_st.fsm   = mux_mode_i ? HS_ADDR : HS_STRB;
                end
            end
            HS_ADDR: begin
                if (last) begin
                    nxt_st.fsm = HS_GAP;
                end
            end
            HS_GAP: begin
                if (last) begin
                    nxt_st.fsm = HS_STRB;
                end
            end
            HS_STRB: begin
                if (last) begin
                    nxt_st.fsm = HS_END;
                    if (!st_ff.write) begin
                        nxt_st.rdata = s_bus;
                    end
                end
            end
            HS_END: begin
                if (last) begin
                    nxt_st.fsm  = HS_IDLE;
                    nxt_st.done = 1'b1;
                    nxt_st.busy = 1'b0;
                end
            end
            default: begin
                nxt_st = HOST_RST;
            end
        endcase
        if (nxt_st.fsm != st_ff.fsm) begin
            nxt_st.cnt = '0;
        end

        // Pins follow the state being entered
        nxt_st.cs_n = ~(nxt_st.fsm == HS_STRB
                      || nxt_st.fsm == HS_END);
        nxt_st.strobe_a = 1'b1;
        nxt_st.strobe_b = ds_style_i ? ~nxt_st.write : 1'b1;
        if (nxt_st.fsm == HS_STRB) begin
            nxt_st.strobe_a = ds_style_i ? 1'b0 : nxt_st.write;
            nxt_st.strobe_b = ~nxt_st.write;
        end
        // Leaving the strobe phase gives the completing rising edge
        nxt_st.ale = mux_mode_i ? (nxt_st.fsm == HS_ADDR)
                                : ds_style_i;
        nxt_st.sel = mux_mode_i ? '0 : nxt_st.addr;
        if (nxt_st.fsm == HS_ADDR || nxt_st.fsm == HS_GAP) begin
            nxt_st.bus_oe  = 1'b1;
            nxt_st.bus_out = {{(HBI_DW-HBI_AW){1'b0}}, nxt_st.addr};
        end else begin
            nxt_st.bus_oe  = nxt_st.write && (nxt_st.fsm == HS_STRB
                                           || nxt_st.fsm == HS_END);
            nxt_st.bus_out = nxt_st.wdata;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_ff <= HOST_RST;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign bus.cs_n            = st_ff.cs_n;
    assign bus.strobe_a        = st_ff.strobe_a;
    assign bus.strobe_b        = st_ff.strobe_b;
    assign bus.ale             = st_ff.ale;
    assign bus.reg_select      = st_ff.sel;
    assign bus.device_clear_in = st_ff.clear;
    assign bus.bus_host_out    = st_ff.bus_out;
    assign bus.bus_host_oe     = st_ff.bus_oe;

    assign busy_o  = st_ff.busy;
    assign done_o  = st_ff.done;
    assign rdata_o = st_ff.rdata;
    assign irq_o   = st_ff.irq;

endmodule

/* tb/hbi_properties.sv */
// Purpose: Pin checks between the host and device ends.
// Assumes: One clock; sys_rst_i asynchronous, active high.
// Notes:   Device sees pins through a 3-4 cycle synchroniser,
//          so response windows allow for that delay.
module hbi_properties (
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    input  wire logic ds_style_i,
    input  wire logic mux_mode_i,
    input  wire logic cs_n,
    input  wire logic strobe_a,
    input  wire logic strobe_b,
    input  wire logic ale,
    input  wire logic device_clear_in,
    input  wire logic bus_host_oe,
    input  wire logic bus_dev_oe,
    input  wire logic irq_dev_out,
    input  wire logic irq_dev_oe,
    input  wire logic irq_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------
    // Pin relations
    // ----------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_strobe_sel: assert property (
        (!strobe_a || (!ds_style_i && !strobe_b)) |-> !cs_n)
        else $error("strobe active while deselected");
    chk_read_start: assert property (
        $rose(bus_dev_oe) |->
        !$past(cs_n, 3) && !$past(strobe_a, 3) && $past(strobe_b, 3))
        else $error("device drove bus without a selected read");
    chk_read_end: assert property (
        $rose(strobe_a) && bus_dev_oe |->
        bus_dev_oe[*3] ##[1:3] !bus_dev_oe)
        else $error("device bus drive did not end after read");
    chk_no_fight: assert property (
        !(bus_dev_oe && bus_host_oe))
        else $error("both ends drive the shared bus");
    chk_irq_pull: assert property (
        irq_dev_oe |-> !irq_dev_out && !irq_n)
        else $error("interrupt not pulled low when enabled");
    chk_clear_len: assert property (
        $fell(device_clear_in) |-> $past(device_clear_in, 4))
        else $error("device clear shorter than four clocks");
    chk_addr_phase: assert property (
        mux_mode_i && ale |-> bus_host_oe && cs_n)
        else $error("address phase without address on bus");
    chk_addr_first: assert property (
        mux_mode_i && $fell(cs_n) |-> !ale && $past(ale, 18))
        else $error("select without prior address phase");
    chk_demux_ale: assert property (
        !mux_mode_i && !cs_n |-> ale == ds_style_i)
        else $error("latch strobe level wrong for demux style");
    chk_dir_hold: assert property (
        ds_style_i && !cs_n && !$past(cs_n) |-> $stable(strobe_b))
        else $error("direction changed during access");
    chk_strobe_len: assert property (
        $changed(strobe_a) |=> $stable(strobe_a)[*4])
        else $error("strobe level held under five cycles");

    cov_write: cover property (!ds_style_i && !cs_n && $rose(strobe_b));
    cov_ds: cover property (ds_style_i && $rose(strobe_a));
    cov_read: cover property ($rose(bus_dev_oe));
    cov_irq: cover property ($rose(irq_dev_oe));
endmodule

/* tb/host_bus_interface_test.sv */
// Purpose: Host requests through both ends in all four bus styles.
// Assumes: Both ends share clock_i, sys_rst_i and the style pins.
// Notes:   Each style starts from a fresh reset, so reset values
//          are rechecked after earlier traffic.
`include "hbi_regs.svh"
module host_bus_interface_test
    import hbi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic      clock_i;
    logic      sys_rst_i;
    logic      ce_i;
    logic      ds_style_i;
    logic      mux_mode_i;
    logic      req_i;
    logic      req_write_i;
    hbi_addr_t req_addr_i;
    hbi_byte_t req_wdata_i;
    hbi_byte_t ovf_event_i;
    logic      busy_o;
    logic      done_o;
    hbi_byte_t rdata_o;
    logic      irq_o;
    hbi_byte_t cfg0_o;
    hbi_byte_t cfg1_o;
    hbi_byte_t flags_o;
    logic      irq_pending_o;
    logic      wr_pulse_o;
    hbi_addr_t wr_idx_o;
    hbi_addr_t wr_last;
    int        wr_seen;
    int        fail_count;
    int        checked;

    hbi_if i_hbi_if ();

    hbi_dev i_hbi_dev (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .ds_style_i(ds_style_i), .mux_mode_i(mux_mode_i),
        .ovf_event_i(ovf_event_i), .cfg0_o(cfg0_o), .cfg1_o(cfg1_o),
        .conference_overflow_flags_o(flags_o),
        .irq_pending_o(irq_pending_o), .wr_pulse_o(wr_pulse_o),
        .wr_idx_o(wr_idx_o), .bus(i_hbi_if)
    );

    hbi_host i_hbi_host (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .ds_style_i(ds_style_i), .mux_mode_i(mux_mode_i),
        .req_i(req_i), .req_write_i(req_write_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
        .irq_o(irq_o), .bus(i_hbi_if)
    );

    hbi_properties i_hbi_properties (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .ds_style_i(ds_style_i), .mux_mode_i(mux_mode_i),
        .cs_n(i_hbi_if.cs_n), .strobe_a(i_hbi_if.strobe_a),
        .strobe_b(i_hbi_if.strobe_b), .ale(i_hbi_if.ale),
        .device_clear_in(i_hbi_if.device_clear_in),
        .bus_host_oe(i_hbi_if.bus_host_oe),
        .bus_dev_oe(i_hbi_if.bus_dev_oe),
        .irq_dev_out(i_hbi_if.irq_dev_out),
        .irq_dev_oe(i_hbi_if.irq_dev_oe), .irq_n(i_hbi_if.irq_n)
    );

    // ----------------------------------------------------------
    // Clock, write monitor and shared tasks
    // ----------------------------------------------------------
    always #5 clock_i = ~clock_i;

    // Counting pulses catches both lost and doubled writes
    always @(posedge clock_i) begin
        if (wr_pulse_o === 1'b1) begin
            wr_seen <= wr_seen + 1;
            wr_last <= wr_idx_o;
        end
    end

    task automatic cmp8(input string what, input hbi_byte_t exp,
                        input hbi_byte_t got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp1(input string what, input logic exp,
                        input logic got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int n;
        for (n = 0; n < 100 && busy_o !== 1'b0; n++) @(negedge clock_i);
        if (busy_o !== 1'b0) begin
            cmp1("busy_o", 1'b0, busy_o);
            give_verdict();
        end
    endtask

    task automatic do_reset(input logic ds, input logic mux);
        @(negedge clock_i);
        sys_rst_i = 1'b1;
        ds_style_i = ds;
        mux_mode_i = mux;
        repeat (5) @(negedge clock_i);
        sys_rst_i = 1'b0;
        wait_idle();
    endtask

    task automatic access(input logic wr, input hbi_addr_t a,
                          input hbi_byte_t d);
        int n;
        int n0;
        wait_idle();
        n0 = wr_seen;
        req_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        @(negedge clock_i);
        req_i = 1'b0;
        for (n = 0; n < 100 && done_o !== 1'b1; n++) @(negedge clock_i);
        if (done_o !== 1'b1) begin
            cmp1("done_o", 1'b1, done_o);
            give_verdict();
        end
        if (wr) begin
            cmp8("write pulses", 8'h01, 8'(wr_seen - n0));
            cmp8("write index", {6'h00, a}, {6'h00, wr_last});
        end
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic check_reset_values();
        hbi_byte_t exp [4];
        exp = '{`HBI_RST_CFG, `HBI_RST_CFG, `HBI_RST_OVF, `HBI_RST_MASK};
        cmp8("cfg0_o", `HBI_RST_CFG, cfg0_o);
        cmp8("flags_o", `HBI_RST_OVF, flags_o);
        for (int i = 0; i < 4; i++) begin
            access(1'b0, hbi_addr_t'(i), 8'h00);
            cmp8("reset read", exp[i], rdata_o);
        end
    endtask

    task automatic check_write_read();
        hbi_byte_t d;
        d = {6'h00, ds_style_i, mux_mode_i} ^ 8'hA5;
        access(1'b1, `HBI_IDX_CFG0, d);
        access(1'b1, `HBI_IDX_CFG1, ~d);
        cmp8("cfg0_o", d, cfg0_o);
        cmp8("cfg1_o", ~d, cfg1_o);
        access(1'b0, `HBI_IDX_CFG0, 8'h00);
        cmp8("cfg0 read", d, rdata_o);
        access(1'b0, `HBI_IDX_CFG1, 8'h00);
        cmp8("cfg1 read", ~d, rdata_o);
    endtask

    task automatic check_overflow();
        int n;
        @(negedge clock_i);
        ovf_event_i = 8'h24;
        @(negedge clock_i);
        ovf_event_i = 8'h00;
        for (n = 0; n < 20 && flags_o !== 8'h24; n++) @(negedge clock_i);
        cmp8("flags_o", 8'h24, flags_o);
        repeat (10) @(negedge clock_i);
        cmp1("irq_o masked", 1'b0, irq_o);
        cmp1("irq_n idle", 1'b1, i_hbi_if.irq_n);
        access(1'b1, `HBI_IDX_MASK, 8'hFB);
        for (n = 0; n < 20 && irq_o !== 1'b1; n++) @(negedge clock_i);
        cmp1("irq_o", 1'b1, irq_o);
        cmp1("irq_pending_o", 1'b1, irq_pending_o);
        cmp1("irq_n", 1'b0, i_hbi_if.irq_n);
        access(1'b0, `HBI_IDX_OVF, 8'h00);
        cmp8("flags read", 8'h24, rdata_o);
        access(1'b1, `HBI_IDX_OVF, 8'h04);
        for (n = 0; n < 20 && irq_o !== 1'b0; n++) @(negedge clock_i);
        cmp1("irq_o cleared", 1'b0, irq_o);
        cmp8("flags cleared", 8'h20, flags_o);
        // Clock enable low must freeze the flags against new events
        ce_i = 1'b0;
        ovf_event_i = 8'h01;
        repeat (4) @(negedge clock_i);
        ovf_event_i = 8'h00;
        ce_i = 1'b1;
        repeat (2) @(negedge clock_i);
        cmp8("flags frozen", 8'h20, flags_o);
    endtask

    initial begin
        clock_i = 1'b0;
        sys_rst_i = 1'b1;
        ce_i = 1'b1;
        ds_style_i = 1'b0;
        mux_mode_i = 1'b0;
        req_i = 1'b0;
        req_write_i = 1'b0;
        req_addr_i = 2'h0;
        req_wdata_i = 8'h00;
        ovf_event_i = 8'h00;
        wr_seen = 0;
        wr_last = 2'h0;
        fail_count = 0;
        checked = 0;
        for (int m = 0; m < 4; m++) begin
            do_reset(m[1], m[0]);
            check_reset_values();
            check_write_read();
            check_overflow();
        end
        give_verdict();
    end
endmodule
